// ---- rtl/liu_regs.svh ----
// Opcode and field constants of the logical instruction unit
`ifndef LIU_REGS_SVH
`define LIU_REGS_SVH
`define LIU_W 24
`define LIU_OP_AND_MEM 6'h1e
`define LIU_OP_OR_MEM 6'h1d
`define LIU_OP_XOR_MEM 6'h1f
`define LIU_OP_AND_IMM 12'h00e
`define LIU_OP_OR_IMM 12'h004
`define LIU_OP_XOR_IMM 12'h00f
`define LIU_OP_AND_REG 12'h016
`define LIU_OP_OR_REG 12'h018
`define LIU_OP_XOR_REG 12'h017
`define LIU_MOP_HI 23
`define LIU_MOP_LO 18
`define LIU_LOP_HI 23
`define LIU_LOP_LO 12
`define LIU_SRC_HI 11
`define LIU_SRC_LO 6
`define LIU_DST_HI 5
`define LIU_DST_LO 0
`define LIU_SEL_I 0
`define LIU_SEL_J 1
`define LIU_SEL_K 2
`define LIU_SEL_E 3
`define LIU_SEL_A 4
`define LIU_SEL_T 5
`define LIU_NREG 6
`define LIU_CC_RESET 3'h1
`endif

// ---- rtl/liu_pkg.sv ----
// Types of the logical instruction unit
package liu_pkg;
	typedef enum logic [1:0] {LIU_FN_AND = 2'h0, LIU_FN_OR = 2'h1, LIU_FN_XOR = 2'h2} liu_fn_type;
	// Condition code, one-hot: zero, positive, negative
	typedef enum logic [2:0] {LIU_CC_ZERO = 3'h1, LIU_CC_POS = 3'h2, LIU_CC_NEG = 3'h4} liu_cc_type;
	typedef enum logic [2:0] {LIU_ST_IDLE = 3'h1, LIU_ST_WAIT = 3'h2, LIU_ST_DONE = 3'h4} liu_state_type;
endpackage

// ---- rtl/liu_logic_op.sv ----
// Bitwise AND, OR and exclusive-OR across the word
`timescale 1ns/1ps
`include "liu_regs.svh"
module liu_logic_op (
	input wire logic [`LIU_W-1:0] a,
	input wire logic [`LIU_W-1:0] b,
	input wire liu_pkg::liu_fn_type fn,
	output logic [`LIU_W-1:0] y
);
	// Function select
	always_comb begin
		unique case (fn)
			liu_pkg::LIU_FN_AND: y = a & b;
			liu_pkg::LIU_FN_OR: y = a | b;
			liu_pkg::LIU_FN_XOR: y = a ^ b;
			default: y = a & b;
		endcase
	end
endmodule // liu_logic_op

// ---- rtl/liu_unit.sv ----
// Logical instruction group execution unit
`timescale 1ns/1ps
`include "liu_regs.svh"
// Notes on behaviour
// - bitwise AND, OR, XOR over operands
// - opcode 36 ANDs memory into accumulator
// - AND byte touches accumulator bits 7-0 only
// - byte forms set condition from low byte
// - register AND: source 11-6, destination 5-0
// - selector bits one-hot per register
// - several selected registers are ORed first
// - result written to every destination register
// - opcode 35 ORs memory into accumulator
// - OR byte keeps upper accumulator bits
// - register OR source field is union
// - opcode 37 XORs memory into accumulator
// - XOR byte keeps upper accumulator bits
// - register XOR uses one-hot selectors
// - memory/register forms: condition from word
module liu_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [`LIU_W-1:0] instr,
	input wire logic [`LIU_W-1:0] mem_operand,
	input wire logic [`LIU_W-1:0] reg_i,
	input wire logic [`LIU_W-1:0] reg_j,
	input wire logic [`LIU_W-1:0] reg_k,
	input wire logic [`LIU_W-1:0] reg_e,
	input wire logic [`LIU_W-1:0] reg_a,
	input wire logic [`LIU_W-1:0] reg_t,
	output logic done_ff,
	output logic illegal_ff,
	output logic [`LIU_W-1:0] result_ff,
	output logic [`LIU_NREG-1:0] wr_en_ff,
	output logic cc_we_ff,
	output logic [2:0] cc_ff
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic is_mem;
	logic is_imm;
	logic is_reg;
	liu_pkg::liu_fn_type fn;
	logic [5:0] src_sel;
	logic [5:0] dst_sel;
	logic [`LIU_W-1:0] src_val;
	logic [`LIU_W-1:0] dst_val;
	logic [`LIU_W-1:0] op_a;
	logic [`LIU_W-1:0] op_b;
	logic [`LIU_W-1:0] op_y;
	logic [`LIU_W-1:0] nxt_result;

	// OR of all registers whose selector bit is set
	function automatic logic [`LIU_W-1:0] sel_or(input logic [5:0] sel, input logic [`LIU_W-1:0] ri,
		input logic [`LIU_W-1:0] rj, input logic [`LIU_W-1:0] rk, input logic [`LIU_W-1:0] re,
		input logic [`LIU_W-1:0] ra, input logic [`LIU_W-1:0] rt);
		sel_or = ({`LIU_W{sel[`LIU_SEL_I]}} & ri) | ({`LIU_W{sel[`LIU_SEL_J]}} & rj)
			| ({`LIU_W{sel[`LIU_SEL_K]}} & rk) | ({`LIU_W{sel[`LIU_SEL_E]}} & re)
			| ({`LIU_W{sel[`LIU_SEL_A]}} & ra) | ({`LIU_W{sel[`LIU_SEL_T]}} & rt);
	endfunction

	// Sign/zero classification of a value of given width
	function automatic logic [2:0] classify(input logic [`LIU_W-1:0] v, input logic byte_only);
		logic [`LIU_W-1:0] w;
		w = byte_only ? {{(`LIU_W-8){v[7]}}, v[7:0]} : v;
		if (w == '0)
			classify = liu_pkg::LIU_CC_ZERO;
		else if (w[`LIU_W-1])
			classify = liu_pkg::LIU_CC_NEG;
		else
			classify = liu_pkg::LIU_CC_POS;
	endfunction

	// Opcode classes and function select
	always_comb begin
		is_mem = 1'b0;
		is_imm = 1'b0;
		is_reg = 1'b0;
		fn = liu_pkg::LIU_FN_AND;
		if (instr[`LIU_MOP_HI:`LIU_MOP_LO] == `LIU_OP_AND_MEM) begin
			is_mem = 1'b1;
		end else if (instr[`LIU_MOP_HI:`LIU_MOP_LO] == `LIU_OP_OR_MEM) begin
			is_mem = 1'b1;
			fn = liu_pkg::LIU_FN_OR;
		end else if (instr[`LIU_MOP_HI:`LIU_MOP_LO] == `LIU_OP_XOR_MEM) begin
			is_mem = 1'b1;
			fn = liu_pkg::LIU_FN_XOR;
		end else begin
			unique case (instr[`LIU_LOP_HI:`LIU_LOP_LO])
				`LIU_OP_AND_IMM: is_imm = 1'b1;
				`LIU_OP_OR_IMM: begin
					is_imm = 1'b1;
					fn = liu_pkg::LIU_FN_OR;
				end
				`LIU_OP_XOR_IMM: begin
					is_imm = 1'b1;
					fn = liu_pkg::LIU_FN_XOR;
				end
				`LIU_OP_AND_REG: is_reg = 1'b1;
				`LIU_OP_OR_REG: begin
					is_reg = 1'b1;
					fn = liu_pkg::LIU_FN_OR;
				end
				`LIU_OP_XOR_REG: begin
					is_reg = 1'b1;
					fn = liu_pkg::LIU_FN_XOR;
				end
				default: is_reg = 1'b0;
			endcase
		end
	end

	// Selector fields
	assign src_sel = instr[`LIU_SRC_HI:`LIU_SRC_LO];
	assign dst_sel = instr[`LIU_DST_HI:`LIU_DST_LO];
	// Union-coded OR source still ORs correctly since x|x == x
	assign src_val = sel_or(src_sel, reg_i, reg_j, reg_k, reg_e, reg_a, reg_t);
	assign dst_val = sel_or(dst_sel, reg_i, reg_j, reg_k, reg_e, reg_a, reg_t);

	// ----------------------------------------
	// Operand routing
	// ----------------------------------------
	always_comb begin
		op_a = reg_a;
		op_b = mem_operand;
		if (is_imm) begin
			op_b = {{(`LIU_W-8){1'b0}}, instr[7:0]};
		end else if (is_reg) begin
			op_a = dst_val;
			op_b = src_val;
		end
	end

	liu_logic_op u_op (
		.a(op_a),
		.b(op_b),
		.fn(fn),
		.y(op_y)
	);

	// Byte forms keep accumulator bits 23-8
	assign nxt_result = is_imm ? {reg_a[`LIU_W-1:8], op_y[7:0]} : op_y;

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
			illegal_ff <= 1'b0;
			result_ff <= '0;
			wr_en_ff <= '0;
			cc_we_ff <= 1'b0;
		end else begin
			done_ff <= instr_valid & (is_mem | is_imm | is_reg);
			illegal_ff <= instr_valid & ~(is_mem | is_imm | is_reg);
			result_ff <= nxt_result;
			cc_we_ff <= instr_valid & (is_mem | is_imm | is_reg);
			if (instr_valid & is_reg)
				wr_en_ff <= dst_sel;
			else if (instr_valid & (is_mem | is_imm))
				wr_en_ff <= 6'h10;
			else
				wr_en_ff <= '0;
		end
	end

	// Condition code from byte or word
	always_ff @(posedge clk) begin
		if (!rst_n)
			cc_ff <= `LIU_CC_RESET;
		else if (instr_valid & (is_mem | is_imm | is_reg))
			cc_ff <= classify(nxt_result, is_imm);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_BYTE_UPPER_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && is_imm |=> result_ff[`LIU_W-1:8] == $past(reg_a[`LIU_W-1:8]))
		else $error("byte form changed upper bits");
	AST_REG_WRITE_DEST: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && is_reg |=> wr_en_ff == $past(instr[5:0]))
		else $error("register write enables wrong");
	AST_MEM_WRITES_A: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && is_mem |=> wr_en_ff == 6'h10 && done_ff)
		else $error("memory form must write only accumulator");
	AST_AND_MEM: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && instr[23:18] == 6'h1e |=> result_ff == ($past(mem_operand) & $past(reg_a)))
		else $error("memory AND wrong");
	AST_OR_MEM: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && instr[23:18] == 6'h1d |=> result_ff == ($past(mem_operand) | $past(reg_a)))
		else $error("memory OR wrong");
	AST_XOR_MEM: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && instr[23:18] == 6'h1f |=> result_ff == ($past(mem_operand) ^ $past(reg_a)))
		else $error("memory XOR wrong");
	AST_CC_ZERO_WORD: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && (is_mem || is_reg) |=> (cc_ff == 3'h1) == (result_ff == '0))
		else $error("zero condition mismatch");
	AST_CC_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && is_imm |=> (cc_ff == 3'h1) == (result_ff[7:0] == 8'h00)
		&& (cc_ff == 3'h4) == result_ff[7])
		else $error("byte condition mismatch");
	AST_NO_WRITE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_valid |=> wr_en_ff == '0 && !cc_we_ff)
		else $error("write without instruction");
	AST_AND_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && instr[`LIU_LOP_HI:`LIU_LOP_LO] == `LIU_OP_AND_IMM
		|=> result_ff[7:0] == ($past(instr[7:0]) & $past(reg_a[7:0])))
		else $error("byte AND wrong");
	AST_OR_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && instr[`LIU_LOP_HI:`LIU_LOP_LO] == `LIU_OP_OR_IMM
		|=> result_ff[7:0] == ($past(instr[7:0]) | $past(reg_a[7:0])))
		else $error("byte OR wrong");
	AST_XOR_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && instr[`LIU_LOP_HI:`LIU_LOP_LO] == `LIU_OP_XOR_IMM
		|=> result_ff[7:0] == ($past(instr[7:0]) ^ $past(reg_a[7:0])))
		else $error("byte XOR wrong");
	AST_REFUSED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && !(is_mem || is_imm || is_reg)
		|=> illegal_ff && !done_ff && wr_en_ff == '0 && !cc_we_ff && $stable(cc_ff))
		else $error("refused code changed state");
	AST_CC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_valid |=> $stable(cc_ff))
		else $error("condition changed without instruction");
endmodule // liu_unit

// ---- tb/liu_regfile.sv ----
// General register file and memory operand source facing the unit
`timescale 1ns/1ps
`include "liu_regs.svh"
module liu_regfile (
	input wire logic clk,
	input wire logic [`LIU_NREG-1:0] wr_en,
	input wire logic [`LIU_W-1:0] result,
	output logic [`LIU_NREG-1:0][`LIU_W-1:0] regs,
	output logic [`LIU_W-1:0] mem_operand
);
	logic [`LIU_W-1:0] mem_word = 24'h0;
	// Fetched word is presented with the instruction
	assign mem_operand = mem_word;
	// Every enabled register takes the result
	always @(posedge clk) begin
		for (int n = 0; n < `LIU_NREG; n++) if (wr_en[n]) regs[n] <= result;
	end
	// Preload used by the bench
	task automatic load(input int n, input logic [`LIU_W-1:0] v);
		regs[n] = v;
	endtask
endmodule // liu_regfile

// ---- tb/logical_instruction_unit_bench.sv ----
// Self-checking bench for the logical instruction unit
`timescale 1ns/1ps
`include "liu_regs.svh"
module logical_instruction_unit_bench;
	logic clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
	logic [`LIU_W-1:0] instr = 24'h0, mem_operand, result;
	logic [`LIU_NREG-1:0][`LIU_W-1:0] regs, exp_r;
	logic [`LIU_NREG-1:0] wr_en, g_wr;
	logic done, illegal, cc_we, g_done, g_ill, g_we;
	logic [2:0] cc, g_cc;
	int error_cnt = 0, samples_checked = 0;
	initial forever #2 clk = ~clk;
	liu_unit dut_u (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .mem_operand(mem_operand),
		.reg_i(regs[0]), .reg_j(regs[1]), .reg_k(regs[2]), .reg_e(regs[3]), .reg_a(regs[4]), .reg_t(regs[5]),
		.done_ff(done), .illegal_ff(illegal), .result_ff(result), .wr_en_ff(wr_en), .cc_we_ff(cc_we), .cc_ff(cc));
	liu_regfile pm_u (.clk(clk), .wr_en(wr_en), .result(result), .regs(regs), .mem_operand(mem_operand));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [`LIU_W-1:0] exp, input logic [`LIU_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [2:0] ccof(input logic [`LIU_W-1:0] v, input int sb);
		if (v == 24'h0) return liu_pkg::LIU_CC_ZERO;
		if (v[sb]) return liu_pkg::LIU_CC_NEG;
		return liu_pkg::LIU_CC_POS;
	endfunction
	function automatic logic [`LIU_W-1:0] lop(input int f, input logic [`LIU_W-1:0] a, input logic [`LIU_W-1:0] b);
		return (f == 0) ? (a & b) : (f == 1) ? (a | b) : (a ^ b);
	endfunction
	// One instruction, answer captured, then one edge for the file write
	task automatic run(input logic [`LIU_W-1:0] ins);
		int n;
		n = 0;
		@(posedge clk);
		#1 instr_valid = 1'b1;
		instr = ins;
		exp_r = regs;
		@(posedge clk);
		#1 instr_valid = 1'b0;
		while (done !== 1'b1 && illegal !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 4) begin
			error_cnt++;
			$display("mismatch answer expected pulse seen none");
			close_out();
		end
		g_done = done;
		g_ill = illegal;
		g_wr = wr_en;
		g_cc = cc;
		g_we = cc_we;
		@(posedge clk);
		#1;
	endtask
	task automatic check_regs(input logic [`LIU_NREG-1:0] sel, input logic [`LIU_W-1:0] res);
		for (int n = 0; n < `LIU_NREG; n++) check($sformatf("reg%0d", n), sel[n] ? res : exp_r[n], regs[n]);
		check("wr_en", {18'h0, sel}, {18'h0, g_wr});
	endtask
	// Memory forms: accumulator only, condition from whole word
	task automatic mem_forms();
		logic [5:0] ops [3] = '{`LIU_OP_AND_MEM, `LIU_OP_OR_MEM, `LIU_OP_XOR_MEM};
		logic [`LIU_W-1:0] r;
		for (int n = 0; n < `LIU_NREG; n++) pm_u.load(n, 24'h3c5a00 ^ (24'h000101 << n));
		for (int f = 0; f < 3; f++) begin
			pm_u.load(4, 24'h8f0f3c);
			pm_u.mem_word = 24'hf0ff0c;
			r = lop(f, 24'h8f0f3c, 24'hf0ff0c);
			run({ops[f], 18'h0});
			check_regs(6'h10, r);
			check("cc", {21'h0, ccof(r, 23)}, {21'h0, g_cc});
			check_pulse(1'b1);
		end
		pm_u.load(4, 24'h8f0f3c);
		pm_u.mem_word = 24'h70f0c3;
		run({`LIU_OP_AND_MEM, 18'h0});
		check_regs(6'h10, 24'h0);
		check("cc_zero", {21'h0, liu_pkg::LIU_CC_ZERO}, {21'h0, g_cc});
	endtask
	// Byte forms: upper bits kept, condition from low byte
	task automatic byte_forms();
		logic [11:0] ops [3] = '{`LIU_OP_AND_IMM, `LIU_OP_OR_IMM, `LIU_OP_XOR_IMM};
		logic [`LIU_W-1:0] r;
		for (int f = 0; f < 3; f++) begin
			pm_u.load(4, 24'h1234c5);
			r = lop(f, 24'hc5, 24'h3a);
			r[23:8] = 16'h1234;
			run({ops[f], 4'h0, 8'h3a});
			check_regs(6'h10, r);
			check("cc", {21'h0, ccof({16'h0, r[7:0]}, 7)}, {21'h0, g_cc});
			check_pulse(1'b1);
		end
	endtask
	// Register forms with grouped selectors, then a refused code
	task automatic reg_forms();
		logic [11:0] ops [3] = '{`LIU_OP_AND_REG, `LIU_OP_OR_REG, `LIU_OP_XOR_REG};
		logic [5:0] src [3] = '{6'h05, 6'h03, 6'h30};
		logic [5:0] dst [3] = '{6'h12, 6'h02, 6'h09};
		logic [`LIU_W-1:0] s, d;
		for (int f = 0; f < 3; f++) begin
			for (int n = 0; n < 6; n++) pm_u.load(n, 24'h813577 ^ (24'h0f0c03 << n));
			#0 s = 24'h0;
			d = 24'h0;
			for (int n = 0; n < 6; n++) s |= src[f][n] ? regs[n] : 24'h0;
			for (int n = 0; n < 6; n++) d |= dst[f][n] ? regs[n] : 24'h0;
			run({ops[f], src[f], dst[f]});
			check_regs(dst[f], lop(f, s, d));
			check("cc", {21'h0, ccof(lop(f, s, d), 23)}, {21'h0, g_cc});
			check_pulse(1'b1);
		end
		run(24'h015042);
		check("refused", 24'h1, {23'h0, g_ill & ~g_done});
		check_regs(6'h0, 24'h0);
		check("cc_kept", {21'h0, ccof(lop(2, s, d), 23)}, {21'h0, g_cc});
		check_pulse(1'b0);
	endtask
	// Answer strobes of the last instruction
	task automatic check_pulse(input logic ok);
		check("done", {23'h0, ok}, {23'h0, g_done});
		check("illegal", {23'h0, ~ok}, {23'h0, g_ill});
		check("cc_we", {23'h0, ok}, {23'h0, g_we});
	endtask
	// Reset in mid-run clears the strobes and sets the condition to LIU_CC_RESET (zero code)
	task automatic reset_mid();
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 check("cc_reset", {21'h0, `LIU_CC_RESET}, {21'h0, cc});
		check("strobes_reset", 24'h0, {15'h0, done, illegal, cc_we, wr_en});
		check("result_reset", 24'h0, result);
		rst_n = 1'b1;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		mem_forms();
		byte_forms();
		reset_mid();
		reg_forms();
		close_out();
	end
endmodule // logical_instruction_unit_bench
